// file: hdl/csc_params.svh
// constants for the card supply, card clock and wait timer block
// assumes a 100 MHz MCLK and a 50 MHz PLL clock sampled as a plain input
//
// Contract
// - 32-bit reload loads wait counter, etu-clocked, enabled
// - uart mode reloads counter at each start bit
// - 6-bit select picks pll divider from table
// - no card supply while presence pin inactive
// - presence loss forces converter power-off sequence
// - deactivation sequence runs whenever converter switches off
// - writing converter_on one starts the converter while a card is present
// - writing converter_on zero shuts converter down
// - ready flag set when usable, cleared when off
// - loaded flag high while loaded and running
// - 2-bit voltage select: 1.8V, 3V or 5V
// - start-up time depends on voltage, at least 20us
// - etu equals unit value minus half compensation
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// register byte offsets
`define CSC_OFS_SLEW 8'hEE
`define CSC_OFS_CONV 8'hEF
`define CSC_OFS_CLKSEL 8'hF0
`define CSC_OFS_WT0 8'hE0
`define CSC_OFS_WT1 8'hE1
`define CSC_OFS_WT2 8'hE2
`define CSC_OFS_WT3 8'hE3
`define CSC_OFS_CTRL 8'hE4
`define CSC_OFS_ETUL 8'hE5
`define CSC_OFS_ETUH 8'hE6
`define CSC_OFS_IRQ_ST 8'hE7
`define CSC_OFS_IRQ_MSK 8'hE8

// field positions
`define CSC_BIT_CONV_ON 7
`define CSC_BIT_CONV_RDY 6
`define CSC_BIT_CONV_LOAD 5
`define CSC_BIT_WAIT_EN 0
`define CSC_BIT_UART 1
`define CSC_BIT_VSEL_LO 2
`define CSC_BIT_COMP 7

// interrupt status bits
`define CSC_IRQ_WAIT 0
`define CSC_IRQ_RDY 1
`define CSC_IRQ_PRES 2

// reset values
`define CSC_RST_CLKSEL 6'h04
`define CSC_RST_ETU 11'h174
`define CSC_RST_SLEW 4'h0

// timing
`define CSC_CLK_MHZ 100
`define CSC_START_US_18 20
`define CSC_START_US_3 30
`define CSC_START_US_5 40
`define CSC_STOP_US 10
`define CSC_CYC(us) ((us) * `CSC_CLK_MHZ)

`endif

// file: hdl/csc_pkg.sv
// types for the card supply, card clock and wait timer block
// state and voltage codes are fixed here, not taken from csc_params.svh
package csc_pkg;
    // converter sequencing states, gray along off-start-ready-stop
    typedef enum logic [1:0] {
        CSC_OFF = 2'b00,
        CSC_START = 2'b01,
        CSC_RUN = 2'b11,
        CSC_STOP = 2'b10
    } csc_conv_t;
    // card voltage codes
    typedef enum logic [1:0] {
        CSC_V_NONE = 2'b00,
        CSC_V_18 = 2'b01,
        CSC_V_3 = 2'b10,
        CSC_V_5 = 2'b11
    } csc_volt_t;
endpackage

// file: hdl/csc_card_supply.sv
// card supply converter sequencing, card clock divider, wait timer
// assumes a single MCLK domain; pll clock and pins sampled synchronously
`timescale 1ns/1ps
`include "csc_params.svh"

module csc_card_supply
    import csc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic PLL_CLK,
    input wire logic CARD_PRESENT_PIN,
    input wire logic START_BIT,
    output logic CARD_CLK,
    output logic CONV_ENABLE,
    output logic [1:0] CARD_VOLTAGE,
    output logic CARD_SUPPLY_ON,
    output logic [3:0] SLEW_SETTING,
    output logic WAIT_TIMEOUT,
    output logic IRQ
);

    // software state
    logic [3:0] slew_ff; // slew setting
    logic conv_on_ff; // converter_on
    logic [5:0] clksel_ff; // card_clock_select
    logic [31:0] reload_ff; // wait_reload_value
    logic wait_en_ff; // wait_count_enable
    logic uart_ff; // uart mode
    logic [1:0] vsel_ff; // card_voltage_select
    logic [10:0] etu_ff; // unit value
    logic comp_ff; // compensation bit
    logic [2:0] irq_st_ff; // sticky events
    logic [2:0] irq_msk_ff; // interrupt mask
    // hardware state
    csc_conv_t conv_ff; // converter sequencer
    logic [12:0] seq_cnt_ff; // start/stop interval counter
    logic [31:0] wtc_ff; // wait_time_counter
    logic [11:0] etu_cnt_ff; // etu prescaler, half-clock units
    logic pll_q_ff; // previous pll sample
    logic [7:0] div_cnt_ff; // pll edge counter
    logic card_clk_ff;
    logic pres_q_ff; // previous presence
    logic [7:0] rdata_ff;
    logic timeout_ff;

    logic [7:0] div_half; // half of selected divider
    logic pll_rise;
    logic card_edge; // one card clock half-period
    logic etu_tick;
    logic [11:0] etu_half; // etu in card half-periods
    logic conv_ready;
    logic conv_loaded;
    logic [12:0] start_cycles;
    logic ev_wait, ev_rdy, ev_pres;

    // divider table, reserved codes fall back to the slowest
    always_comb begin
        unique case (clksel_ff)
            6'h00: div_half = 8'h04;
            6'h01: div_half = 8'h06;
            6'h02: div_half = 8'h08;
            6'h03: div_half = 8'h0A;
            6'h04: div_half = 8'h0C;
            6'h05: div_half = 8'h18;
            6'h06: div_half = 8'h20;
            6'h07: div_half = 8'h28;
            6'h08: div_half = 8'h30;
            6'h09: div_half = 8'h40;
            6'h0A: div_half = 8'h50;
            default: div_half = 8'h60; // 0x0B and reserved codes
        endcase
    end

    // start-up time by voltage, never under the 20us floor
    always_comb begin
        unique case (vsel_ff)
            CSC_V_3: start_cycles = 13'(`CSC_CYC(`CSC_START_US_3));
            CSC_V_5: start_cycles = 13'(`CSC_CYC(`CSC_START_US_5));
            default: start_cycles = 13'(`CSC_CYC(`CSC_START_US_18));
        endcase
    end

    assign pll_rise = PLL_CLK & ~pll_q_ff;
    // >= so a count left high by a switch to a faster code ends at once
    assign card_edge = pll_rise && (div_cnt_ff >= div_half - 8'h01);
    // etu less half a card clock when compensating, in half-periods
    assign etu_half = {etu_ff, 1'b0} - {11'h000, comp_ff};
    assign etu_tick = card_edge && (etu_cnt_ff >= etu_half - 12'h001);
    assign conv_ready = (conv_ff == CSC_RUN);
    assign conv_loaded = conv_ready;

    // pll edge detect and card clock divider
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pll_q_ff <= 1'b0;
            div_cnt_ff <= 8'h00;
            card_clk_ff <= 1'b0;
        end else begin
            pll_q_ff <= PLL_CLK;
            if (card_edge) begin
                div_cnt_ff <= 8'h00;
                card_clk_ff <= ~card_clk_ff;
            end else if (pll_rise) begin
                div_cnt_ff <= div_cnt_ff + 8'h01;
            end
        end
    end

    // etu prescaler counts card half-periods
    always_ff @(posedge MCLK) begin
        if (SRST || !wait_en_ff) begin
            etu_cnt_ff <= 12'h000;
        end else if (etu_tick) begin
            etu_cnt_ff <= 12'h000;
        end else if (card_edge) begin
            etu_cnt_ff <= etu_cnt_ff + 12'h001;
        end
    end

    // wait time counter, counts down one per etu
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            wtc_ff <= 32'h0000_0000;
            timeout_ff <= 1'b0;
        end else if (!wait_en_ff || (uart_ff && START_BIT)) begin
            wtc_ff <= reload_ff;
            timeout_ff <= 1'b0;
        end else if (etu_tick && wtc_ff != 32'h0000_0000) begin
            wtc_ff <= wtc_ff - 32'h0000_0001;
            timeout_ff <= (wtc_ff == 32'h0000_0001);
        end
    end
    assign ev_wait = etu_tick && wait_en_ff && !(uart_ff && START_BIT)
        && (wtc_ff == 32'h0000_0001);

    // converter sequencer
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            conv_ff <= CSC_OFF;
            seq_cnt_ff <= 13'h0000;
        end else begin
            unique case (conv_ff)
                CSC_OFF: begin
                    // refuse start while card absent
                    if (conv_on_ff && CARD_PRESENT_PIN) begin
                        conv_ff <= CSC_START;
                        seq_cnt_ff <= start_cycles;
                    end
                end
                CSC_START, CSC_RUN: begin
                    if (!conv_on_ff || !CARD_PRESENT_PIN) begin
                        conv_ff <= CSC_STOP;
                        seq_cnt_ff <= 13'(`CSC_CYC(`CSC_STOP_US));
                    end else if (conv_ff == CSC_START) begin
                        if (seq_cnt_ff == 13'h0001) begin
                            conv_ff <= CSC_RUN;
                        end
                        seq_cnt_ff <= seq_cnt_ff - 13'h0001;
                    end
                end
                CSC_STOP: begin
                    // deactivation runs to its end before restart
                    if (seq_cnt_ff == 13'h0001) begin
                        conv_ff <= CSC_OFF;
                    end
                    seq_cnt_ff <= seq_cnt_ff - 13'h0001;
                end
            endcase
        end
    end
    assign ev_rdy = (conv_ff == CSC_START) && conv_on_ff
        && CARD_PRESENT_PIN && (seq_cnt_ff == 13'h0001);
    assign ev_pres = pres_q_ff && !CARD_PRESENT_PIN;

    // register writes
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            slew_ff <= `CSC_RST_SLEW;
            conv_on_ff <= 1'b0;
            clksel_ff <= `CSC_RST_CLKSEL;
            reload_ff <= 32'h0000_0000;
            wait_en_ff <= 1'b0;
            uart_ff <= 1'b0;
            vsel_ff <= 2'b00;
            etu_ff <= `CSC_RST_ETU;
            comp_ff <= 1'b0;
            irq_msk_ff <= 3'h0;
        end else if (WR) begin
            // read-only and reserved bits are simply not stored
            unique case (ADDR)
                `CSC_OFS_SLEW: slew_ff <= WDATA[3:0];
                `CSC_OFS_CONV: conv_on_ff <= WDATA[`CSC_BIT_CONV_ON];
                `CSC_OFS_CLKSEL: clksel_ff <= WDATA[5:0];
                `CSC_OFS_WT0: reload_ff[7:0] <= WDATA;
                `CSC_OFS_WT1: reload_ff[15:8] <= WDATA;
                `CSC_OFS_WT2: reload_ff[23:16] <= WDATA;
                `CSC_OFS_WT3: reload_ff[31:24] <= WDATA;
                `CSC_OFS_CTRL: begin
                    wait_en_ff <= WDATA[`CSC_BIT_WAIT_EN];
                    uart_ff <= WDATA[`CSC_BIT_UART];
                    // no checks: software keeps this steady while loaded
                    vsel_ff <= WDATA[`CSC_BIT_VSEL_LO +: 2];
                end
                `CSC_OFS_ETUL: etu_ff[7:0] <= WDATA;
                `CSC_OFS_ETUH: begin
                    etu_ff[10:8] <= WDATA[2:0];
                    comp_ff <= WDATA[`CSC_BIT_COMP];
                end
                `CSC_OFS_IRQ_MSK: irq_msk_ff <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    // sticky events, set wins over write-one-to-clear
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            irq_st_ff <= 3'h0;
            pres_q_ff <= 1'b0;
        end else begin
            pres_q_ff <= CARD_PRESENT_PIN;
            irq_st_ff <= (irq_st_ff
                & ~((WR && ADDR == `CSC_OFS_IRQ_ST) ? WDATA[2:0] : 3'h0))
                | {ev_pres, ev_rdy, ev_wait};
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge MCLK) begin
        if (SRST || !RD) begin
            rdata_ff <= 8'h00;
        end else begin
            unique case (ADDR)
                `CSC_OFS_SLEW: rdata_ff <= {4'h0, slew_ff};
                `CSC_OFS_CONV: rdata_ff <= {conv_on_ff, conv_ready,
                    conv_loaded, 5'h00};
                `CSC_OFS_CLKSEL: rdata_ff <= {2'b00, clksel_ff};
                `CSC_OFS_WT0: rdata_ff <= reload_ff[7:0];
                `CSC_OFS_WT1: rdata_ff <= reload_ff[15:8];
                `CSC_OFS_WT2: rdata_ff <= reload_ff[23:16];
                `CSC_OFS_WT3: rdata_ff <= reload_ff[31:24];
                `CSC_OFS_CTRL: rdata_ff <= {4'h0, vsel_ff, uart_ff,
                    wait_en_ff};
                `CSC_OFS_ETUL: rdata_ff <= etu_ff[7:0];
                `CSC_OFS_ETUH: rdata_ff <= {comp_ff, 4'h0, etu_ff[10:8]};
                `CSC_OFS_IRQ_ST: rdata_ff <= {5'h00, irq_st_ff};
                `CSC_OFS_IRQ_MSK: rdata_ff <= {5'h00, irq_msk_ff};
                default: rdata_ff <= 8'h00; // unmapped reads zero
            endcase
        end
    end

    // registered pin outputs
    logic conv_en_ff, supply_ff, irq_ff;
    logic [1:0] volt_ff;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            conv_en_ff <= 1'b0;
            supply_ff <= 1'b0;
            volt_ff <= 2'b00;
            irq_ff <= 1'b0;
        end else begin
            conv_en_ff <= (conv_ff == CSC_START) || conv_ready;
            // supply only when ready and card still there
            supply_ff <= conv_ready && CARD_PRESENT_PIN;
            volt_ff <= vsel_ff;
            irq_ff <= |(irq_st_ff & irq_msk_ff);
        end
    end

    assign RDATA = rdata_ff;
    assign CARD_CLK = card_clk_ff;
    assign CONV_ENABLE = conv_en_ff;
    assign CARD_VOLTAGE = volt_ff;
    assign CARD_SUPPLY_ON = supply_ff;
    assign SLEW_SETTING = slew_ff;
    assign WAIT_TIMEOUT = timeout_ff;
    assign IRQ = irq_ff;

endmodule

// file: testbench/csc_card_supply_checker.sv
// port assertions for the card supply block
// assumes a bind from the bench top file and one MCLK domain
`timescale 1ns/1ps
module csc_card_supply_checker (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic CARD_PRESENT_PIN,
    input wire logic CARD_CLK,
    input wire logic CONV_ENABLE,
    input wire logic [1:0] CARD_VOLTAGE,
    input wire logic CARD_SUPPLY_ON,
    input wire logic [3:0] SLEW_SETTING
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    int run_ff; // cycles with the converter powered
    int nxt_run;
    int min_run; // shortest legal start-up for the voltage
    always_comb nxt_run = CONV_ENABLE ? run_ff + 1 : 0;
    always_comb min_run = 1000 * int'(CARD_VOLTAGE) + 990;
    // reset wins so a mid-run reset restarts the count
    always_ff @(posedge MCLK) run_ff <= SRST ? 0 : nxt_run;
    sequence absent_sq;
        !CARD_PRESENT_PIN [*5];
    endsequence
    sequence off_wr_sq;
        WR && ADDR == 8'hEF && !WDATA[7] && CONV_ENABLE;
    endsequence
    no_supply_a: assert property (
        absent_sq |-> !CARD_SUPPLY_ON && !CONV_ENABLE)
        else $error("supply up with card absent");
    loss_off_a: assert property (
        $fell(CARD_PRESENT_PIN) |-> ##[0:4] !CONV_ENABLE)
        else $error("converter kept on after removal");
    off_write_a: assert property (
        off_wr_sq |-> ##[1:4] !CONV_ENABLE)
        else $error("converter kept on after off write");
    start_len_a: assert property (
        $rose(CARD_SUPPLY_ON) |-> run_ff >= min_run)
        else $error("start-up too short");
    rd_idle_a: assert property (
        !$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read cycle");
    conv_rd_a: assert property (
        RD && ADDR == 8'hEF |=> RDATA[4:0] == 5'h00 && RDATA[6] == RDATA[5])
        else $error("converter flags inconsistent");
    clk_min_a: assert property (
        $changed(CARD_CLK) |=> $stable(CARD_CLK) [*7])
        else $error("card clock half period below 8");
    slew_copy_a: assert property (
        WR && ADDR == 8'hEE |-> ##2 SLEW_SETTING == $past(WDATA[3:0], 2))
        else $error("slew copy wrong");
endmodule

// file: testbench/csc_card_partner.sv
// card side stand-in: presence switch, start bits, pll clock
// assumes the bench steers insertion and start-bit requests
`timescale 1ns/1ps
module csc_card_partner (
    input wire logic mclk,
    input wire logic insert_req,
    input wire logic bit_req,
    output logic pll_clk,
    output logic card_present,
    output logic start_bit
);
    logic pres_ff = 1'b0; // switch level, card out at power-up
    logic bit_ff = 1'b0; // one-cycle start-bit pulse
    assign card_present = pres_ff;
    assign start_bit = bit_ff;
    // free-running pll, kept off the mclk edges to avoid races
    initial begin
        pll_clk = 1'b0;
        #2;
        forever #10 pll_clk = ~pll_clk;
    end
    // switch and uart line follow requests one edge late
    always @(posedge mclk) begin
        pres_ff <= insert_req;
        bit_ff <= bit_req;
    end
endmodule

// file: testbench/csc_card_supply_tb.sv
// bench top: design, card stand-in, checker bind and scenarios
// assumes 100 MHz MCLK and the register map of csc_params.svh
`timescale 1ns/1ps
module csc_card_supply_tb;
    logic mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic insert = 1'b1, bit_req = 1'b0; // card in, no start bit
    logic pll, present, sbit, cclk, conv_en, supply_on, timeout, irq;
    logic [1:0] volt;
    logic [3:0] slew;
    logic [31:0] seed = 32'h0000_0046;
    int failures = 0, n_tests = 0, cycles = 0, n;
    int mdl[256]; // register model: expected read values
    int wmask[256]; // writable bits per offset
    int half[13] = '{8, 12, 16, 20, 24, 48, 64, 80, 96, 128, 160, 192, 192};
    // unsigned so the offsets index the model arrays directly
    logic [7:0] ofs[6] = '{8'hEE, 8'hEF, 8'hF0, 8'hE5, 8'hE6, 8'h10};
    csc_card_supply csc_card_supply_i (.MCLK(mclk), .SRST(srst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PLL_CLK(pll), .CARD_PRESENT_PIN(present), .START_BIT(sbit),
        .CARD_CLK(cclk), .CONV_ENABLE(conv_en), .CARD_VOLTAGE(volt),
        .CARD_SUPPLY_ON(supply_on), .SLEW_SETTING(slew),
        .WAIT_TIMEOUT(timeout), .IRQ(irq));
    csc_card_partner csc_card_partner_i (.mclk(mclk), .insert_req(insert),
        .bit_req(bit_req), .pll_clk(pll), .card_present(present),
        .start_bit(sbit));
    always #5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        mdl[a] = (v & wmask[a]) | (mdl[a] & ~wmask[a]);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // cycles until the card clock next changes, bounded
    task automatic tgl(output int k);
        logic l;
        l = cclk;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (cclk === l && k < 500);
    endtask
    // hang guard, well above the roughly 20k cycles of the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        foreach (mdl[i]) begin
            mdl[i] = 0;
            wmask[i] = 0;
        end
        wmask[8'hEE] = 8'h0F;
        wmask[8'hF0] = 8'h3F;
        mdl[8'hF0] = 8'h04;
        mdl[8'hE5] = 8'h74;
        mdl[8'hE6] = 8'h01;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        // reset values, then reserved bits and unmapped place after 0xFF
        repeat (2) begin
            foreach (ofs[i]) begin
                rreg(ofs[i]);
                chk(d, mdl[ofs[i]]);
            end
            wreg(8'hEE, 8'hFF);
            wreg(8'hF0, 8'hFF);
            wreg(8'h10, 8'hFF);
        end
        repeat (4) begin
            seed = xs(seed);
            wreg(8'hEE, seed[7:0]);
            cyc(2);
            chk(slew, seed[3:0]);
        end
        // every divider code, reserved one included
        for (int c = 0; c < 13; c++) begin
            wreg(8'hF0, c[7:0]);
            repeat (3) tgl(n);
            chk(n, half[c]);
        end
        wreg(8'hE8, 8'h02);
        for (int v = 1; v < 4; v++) begin
            wreg(8'hE4, v[7:0] << 2);
            cyc(2);
            chk(volt, v);
            wreg(8'hEF, 8'h80);
            n = 0;
            while (supply_on !== 1'b1 && n < 6000) begin
                cyc(1);
                n++;
            end
            chk(n >= 1000 * v + 1000 && n <= 1000 * v + 1006, 1);
            rreg(8'hEF);
            chk(d, 8'hE0);
            chk(irq, 1);
            wreg(8'hE7, 8'h02);
            cyc(2);
            chk(irq, 0);
            if (v < 3) begin
                wreg(8'hEF, 8'h00);
            end else begin
                insert <= 1'b0;
            end
            cyc(6);
            chk({conv_en, supply_on}, 0);
            cyc(1100);
            rreg(8'hEF);
            chk(d[6:5], 0);
        end
        rreg(8'hE7);
        chk(d[2:1], 2'b10);
        chk(irq, 0);
        wreg(8'hEF, 8'hFF);
        cyc(20);
        chk(conv_en, 0);
        rreg(8'hEF);
        chk(d[6:0], 0);
        wreg(8'hEF, 8'h00);
        insert <= 1'b1;
        // wait timer: 4 units of 11 card clocks at divider 8
        wreg(8'hF0, 8'h00);
        wreg(8'hE5, 8'h0B);
        wreg(8'hE6, 8'h00);
        for (int b = 0; b < 4; b++) wreg(8'hE0 + b[7:0], b == 0 ? 4 : 0);
        wreg(8'hE4, 8'h01);
        cyc(400);
        chk(timeout, 0);
        cyc(600);
        chk(timeout, 1);
        wreg(8'hE4, 8'h03);
        repeat (4) begin
            bit_req <= 1'b1;
            @(posedge mclk);
            bit_req <= 1'b0;
            cyc(400);
            chk(timeout, 0);
        end
        cyc(800);
        chk(timeout, 1);
        final_report();
    end
endmodule
bind csc_card_supply csc_card_supply_checker chk_i (.MCLK(MCLK), .SRST(SRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CARD_PRESENT_PIN(CARD_PRESENT_PIN), .CARD_CLK(CARD_CLK),
    .CONV_ENABLE(CONV_ENABLE), .CARD_VOLTAGE(CARD_VOLTAGE),
    .CARD_SUPPLY_ON(CARD_SUPPLY_ON), .SLEW_SETTING(SLEW_SETTING));
